// ### hdl/t8c_map.svh
// Register map, field positions and timing constants of the 8-bit timer.
// Functional notes
// - Force strobe in non-PWM mode acts as an immediate match on the pin.
// - Forced match sets no flag, no interrupt, never clears the counter.
// - Force strobe reads zero and does nothing in PWM modes.
// - Mode 0 normal, 1 phase PWM, 2 clear-on-match, 3 fast PWM.
// - Any nonzero output mode makes the compare output override the pin.
// - Non-PWM output codes: off, toggle, clear, set on match.
// - Fast PWM: 10 clear on match set at bottom, 11 inverted.
// - Fast PWM with compare at top ignores match, acts at bottom only.
// - Phase PWM: 10 clears on up match, sets on down; 11 inverted.
// - Phase PWM with compare at top ignores match, acts at top only.
// - Clock select: stop, undivided, then divide by 8 up to 1024.
// - Counter is read/write; loading it blocks the match on the next tick.
// - Compare value is compared with the counter; equality is a match.
// - Async select zero uses the bus clock, one uses the crystal pin.
// - Async counter write sets its busy flag until the counter loads.
// - Async compare write sets its busy flag until the compare loads.
// - Async control write sets its busy flag until the control loads.
// - Counter reads live value; compare and control read temporary copy.
// - Async written values load after two rising crystal edges.
// - Match sets the match flag; vector or write-one clears it.
// - Overflow sets its flag, at bottom in phase PWM; same clearing.
`ifndef T8C_MAP_SVH
`define T8C_MAP_SVH

`define T8C_FLAGS_IDX   8'h30
`define T8C_ASYNC_IDX   8'h31
`define T8C_CMP_IDX     8'h32
`define T8C_CTRL_IDX    8'h33
`define T8C_CNT_IDX     8'h34
`define T8C_ADDR_W      10
`define T8C_ADDR(i)     ({(i), 2'b00})

`define T8C_CTRL_RST    8'h00
`define T8C_CTRL_FORCE  7
`define T8C_ASYNC_SEL   3
`define T8C_BUSY_CNT    2
`define T8C_BUSY_CMP    1
`define T8C_BUSY_CTRL   0
`define T8C_FLAG_CMP    1
`define T8C_FLAG_OVF    0

`define T8C_MAX         8'hFF
`define T8C_XFER_EDGES  2'h2
`define T8C_PRE_W       10

`endif

// ### hdl/t8c_pkg.sv
// Types shared by the timer modules.
package t8c_pkg;

  typedef enum logic [1:0] {
    T8C_WM_NORMAL,
    T8C_WM_PHASE,
    T8C_WM_CTC,
    T8C_WM_FAST
  } t8c_wave_t;

  typedef struct packed {
    logic       force_compare_strobe;
    logic       wave_mode_sel_lo;
    logic [1:0] compare_out_mode;
    logic       wave_mode_sel_hi;
    logic [2:0] clk_sel;
  } t8c_ctrl_t;

  typedef struct packed {
    logic       compare_out_pin;
    logic       compare_out_ovr;
    logic       compare_match_flag;
    logic       overflow_flag;
  } t8c_out_t;

endpackage : t8c_pkg

// ### hdl/t8c_prescale.sv
// Prescaler that turns source clock ticks into timer ticks.
`timescale 1ns/1ps
`default_nettype none
`include "t8c_map.svh"
module t8c_prescale (
  // Clock and reset.
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Source tick and divider choice.
  input  wire logic       src_tick,
  input  wire logic [2:0] clk_sel,
  // Timer tick.
  output logic            tick
);

  logic [`T8C_PRE_W-1:0] pre_r;
  logic [`T8C_PRE_W-1:0] mask;

  function automatic logic [`T8C_PRE_W-1:0] div_mask(input logic [2:0] s);
    case (s)
      3'h2:    div_mask = 10'h007;
      3'h3:    div_mask = 10'h01F;
      3'h4:    div_mask = 10'h03F;
      3'h5:    div_mask = 10'h07F;
      3'h6:    div_mask = 10'h0FF;
      3'h7:    div_mask = 10'h3FF;
      default: div_mask = 10'h000;
    endcase
  endfunction : div_mask

  assign mask = div_mask(clk_sel);
  // Stop, undivided, or one tick per full divider period.
  assign tick = src_tick && (clk_sel != 3'h0) && ((pre_r & mask) == mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= '0;
    end else if (src_tick) begin
      pre_r <= pre_r + 10'h001;
    end
  end

endmodule : t8c_prescale
`default_nettype wire

// ### hdl/t8c_timer.sv
// 8-bit timer with one compare channel behind an AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "t8c_map.svh"
module t8c_timer (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Crystal pin and interrupt vector acknowledges.
  input  wire logic        xtal_in_pin,
  input  wire logic        cmp_vector_ack,
  input  wire logic        ovf_vector_ack,
  // Waveform pin and flags.
  output var t8c_pkg::t8c_out_t tmr_out
);

  localparam logic [`T8C_ADDR_W-1:0] A_CTRL  = `T8C_ADDR(`T8C_CTRL_IDX);
  localparam logic [`T8C_ADDR_W-1:0] A_CNT   = `T8C_ADDR(`T8C_CNT_IDX);
  localparam logic [`T8C_ADDR_W-1:0] A_CMP   = `T8C_ADDR(`T8C_CMP_IDX);
  localparam logic [`T8C_ADDR_W-1:0] A_ASYNC = `T8C_ADDR(`T8C_ASYNC_IDX);
  localparam logic [`T8C_ADDR_W-1:0] A_FLAGS = `T8C_ADDR(`T8C_FLAGS_IDX);

  // Bus side state.
  logic                   wr_act_r;
  logic [`T8C_ADDR_W-1:0] wr_addr_r;
  logic [31:0]            hrdata_r;
  // Registers, temporaries and transfer tracking.
  logic                   async_sel_r;
  logic [7:0]             ctrl_tmp_r;
  logic [7:0]             cmp_tmp_r;
  logic [7:0]             cnt_tmp_r;
  t8c_pkg::t8c_ctrl_t     ctrl_r;
  logic [7:0]             ocr_dst_r;
  logic [7:0]             ocr_act_r;
  logic [7:0]             cnt_r;
  logic [7:0]             cnt_nxt;
  logic                   dir_up_r;
  logic                   block_r;
  logic                   force_r;
  logic                   oc_r;
  logic                   oc_nxt;
  logic                   cmp_flag_r;
  logic                   ovf_flag_r;
  logic [2:0]             busy_r;
  logic [1:0]             ecnt_r [3];
  logic                   xs1_r;
  logic                   xs2_r;
  logic                   xs3_r;

  // Address decode and data phase strobes.
  wire        ap_take  = hsel & htrans[1] & hready;
  wire        ap_hi0   = (haddr[31:`T8C_ADDR_W] == '0);
  wire [`T8C_ADDR_W-1:0] ap_a = haddr[`T8C_ADDR_W-1:0];
  wire        wr_ctrl  = wr_act_r & (wr_addr_r == A_CTRL);
  wire        wr_cnt   = wr_act_r & (wr_addr_r == A_CNT);
  wire        wr_cmp   = wr_act_r & (wr_addr_r == A_CMP);
  wire        wr_async = wr_act_r & (wr_addr_r == A_ASYNC);
  wire        wr_flags = wr_act_r & (wr_addr_r == A_FLAGS);
  wire [7:0]  wd       = hwdata[7:0];

  // Crystal edge and the source tick it gives.
  wire        xedge    = xs2_r & ~xs3_r;
  wire        src_tick = async_sel_r ? xedge : 1'b1;
  wire        tick;

  // Temporary to destination transfers.
  wire [2:0]  wr_vec   = {wr_cnt, wr_cmp, wr_ctrl};
  wire [2:0]  xfer_done;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_xfer
      assign xfer_done[gi] = busy_r[gi] & xedge &
                             (ecnt_r[gi] == `T8C_XFER_EDGES - 2'h1);
    end
  endgenerate
  wire ld_ctrl = async_sel_r ? xfer_done[`T8C_BUSY_CTRL] : wr_ctrl;
  wire ld_cmp  = async_sel_r ? xfer_done[`T8C_BUSY_CMP]  : wr_cmp;
  wire ld_cnt  = async_sel_r ? xfer_done[`T8C_BUSY_CNT]  : wr_cnt;
  wire [7:0] ctrl_new = async_sel_r ? ctrl_tmp_r : wd;
  wire [7:0] cmp_new  = async_sel_r ? cmp_tmp_r  : wd;
  wire [7:0] cnt_new  = async_sel_r ? cnt_tmp_r  : wd;

  // Mode decode.
  t8c_pkg::t8c_wave_t wave;
  assign wave = t8c_pkg::t8c_wave_t'({ctrl_r.wave_mode_sel_hi,
                                      ctrl_r.wave_mode_sel_lo});
  wire       is_pc   = (wave == t8c_pkg::T8C_WM_PHASE);
  wire       is_fast = (wave == t8c_pkg::T8C_WM_FAST);
  wire       is_ctc  = (wave == t8c_pkg::T8C_WM_CTC);
  wire [7:0] top_v   = is_ctc ? ocr_act_r : `T8C_MAX;
  wire [1:0] com     = ctrl_r.compare_out_mode;
  wire       ocr_top = (ocr_act_r == `T8C_MAX);

  // Counter events.
  wire at_max    = (cnt_r == `T8C_MAX);
  wire at_top_pc = tick & is_pc & dir_up_r & at_max;
  wire at_bot_pc = tick & is_pc & ~dir_up_r & (cnt_r == 8'h00);
  wire bot_fast  = tick & is_fast & at_max;
  // Equality with the active compare value, unless a counter write
  // blocks this tick.
  wire match_ev  = tick & ~ld_cnt & ~block_r & (cnt_r == ocr_act_r);
  // Overflow at MAX, or at the turn at zero in phase PWM.
  wire ovf_ev    = is_pc ? at_bot_pc : (tick & at_max);
  wire cmp_clr   = cmp_vector_ack | (wr_flags & wd[`T8C_FLAG_CMP]);
  wire ovf_clr   = ovf_vector_ack | (wr_flags & wd[`T8C_FLAG_OVF]);

  t8c_prescale u_prescale (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .src_tick (src_tick),
    .clk_sel  (ctrl_r.clk_sel),
    .tick     (tick)
  );

  // Read data for the address being offered.
  logic [7:0] rd_v;
  always_comb begin
    case (ap_a)
      A_CTRL:  rd_v = {1'b0, ctrl_tmp_r[6:0]};
      A_CNT:   rd_v = cnt_r;
      A_CMP:   rd_v = cmp_tmp_r;
      A_ASYNC: rd_v = {4'h0, async_sel_r, busy_r};
      A_FLAGS: rd_v = {6'h00, cmp_flag_r, ovf_flag_r};
      default: rd_v = 8'h00;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_act_r  <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_act_r  <= ap_take & hwrite & ap_hi0;
      wr_addr_r <= ap_a;
      hrdata_r  <= (ap_take & ~hwrite & ap_hi0) ? {24'h000000, rd_v}
                                                 : 32'h0000_0000;
    end
  end

  // Crystal pin synchroniser; the second and third stages feed the edge detect.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end else begin
      xs1_r <= xtal_in_pin;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end

  // Temporaries, clock select and busy flags.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      async_sel_r <= 1'b0;
      ctrl_tmp_r  <= `T8C_CTRL_RST;
      cmp_tmp_r   <= 8'h00;
      cnt_tmp_r   <= 8'h00;
      busy_r      <= 3'h0;
      for (int i = 0; i < 3; i++) ecnt_r[i] <= 2'h0;
    end else begin
      if (wr_async) async_sel_r <= wd[`T8C_ASYNC_SEL];
      if (wr_ctrl) ctrl_tmp_r <= wd;
      if (wr_cmp) cmp_tmp_r <= wd;
      if (wr_cnt) cnt_tmp_r <= wd;
      for (int i = 0; i < 3; i++) begin
        if (wr_vec[i] & async_sel_r) begin
          busy_r[i] <= 1'b1;
          ecnt_r[i] <= 2'h0;
        end else if (xfer_done[i] | ~async_sel_r) begin
          busy_r[i] <= 1'b0;
          ecnt_r[i] <= 2'h0;
        end else if (busy_r[i] & xedge) begin
          ecnt_r[i] <= ecnt_r[i] + 2'h1;
        end
      end
    end
  end

  // Destination registers and the compare double buffer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= t8c_pkg::t8c_ctrl_t'(`T8C_CTRL_RST);
      ocr_dst_r <= 8'h00;
      ocr_act_r <= 8'h00;
      force_r   <= 1'b0;
    end else begin
      if (ld_ctrl) ctrl_r <= {1'b0, ctrl_new[6:0]};
      if (ld_cmp) ocr_dst_r <= cmp_new;
      if (!wave[0] || at_top_pc || bot_fast) ocr_act_r <= ocr_dst_r;
      // Strobe only in non-PWM modes, judged on the new mode.
      force_r <= ld_ctrl & ctrl_new[`T8C_CTRL_FORCE] & ~ctrl_new[6];
    end
  end

  // Counting sequence.
  always_comb begin
    cnt_nxt = cnt_r;
    if (ld_cnt) begin
      cnt_nxt = cnt_new;
    end else if (tick) begin
      if (is_pc) begin
        if (dir_up_r) cnt_nxt = at_max ? (`T8C_MAX - 8'h01) : cnt_r + 8'h01;
        else cnt_nxt = (cnt_r == 8'h00) ? 8'h01 : cnt_r - 8'h01;
      end else begin
        // A tick at equality with top clears the counter in CTC, even when the match is blocked.
        cnt_nxt = (cnt_r == top_v) ? 8'h00 : cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r    <= 8'h00;
      dir_up_r <= 1'b1;
      block_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (at_top_pc & ~ld_cnt) dir_up_r <= 1'b0;
      else if ((at_bot_pc & ~ld_cnt) | ~is_pc) dir_up_r <= 1'b1;
      if (ld_cnt) block_r <= 1'b1;
      else if (tick) block_r <= 1'b0;
    end
  end

  // Waveform unit.
  always_comb begin
    oc_nxt = oc_r;
    case (wave)
      t8c_pkg::T8C_WM_NORMAL, t8c_pkg::T8C_WM_CTC: begin
        if (match_ev | force_r) begin
          case (com)
            2'h1:    oc_nxt = ~oc_r;
            2'h2:    oc_nxt = 1'b0;
            2'h3:    oc_nxt = 1'b1;
            default: oc_nxt = oc_r;
          endcase
        end
      end
      t8c_pkg::T8C_WM_FAST: begin
        if (bot_fast & com[1]) oc_nxt = ~com[0];
        else if (match_ev & com[1] & ~ocr_top) oc_nxt = com[0];
      end
      t8c_pkg::T8C_WM_PHASE: begin
        if (at_top_pc & com[1] & ocr_top) oc_nxt = ~com[0];
        else if (match_ev & com[1] & ~ocr_top)
          oc_nxt = dir_up_r ? com[0] : ~com[0];
      end
      default: oc_nxt = oc_r;
    endcase
  end

  // Flags: a set in the clearing cycle wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_r       <= 1'b0;
      cmp_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
    end else begin
      oc_r       <= oc_nxt;
      cmp_flag_r <= match_ev | (cmp_flag_r & ~cmp_clr);
      ovf_flag_r <= ovf_ev | (ovf_flag_r & ~ovf_clr);
    end
  end

  assign tmr_out.compare_out_pin    = oc_r;
  assign tmr_out.compare_out_ovr    = |com;
  assign tmr_out.compare_match_flag = cmp_flag_r;
  assign tmr_out.overflow_flag      = ovf_flag_r;

  property p_force_no_flag;
    @(posedge hclk) disable iff (!hresetn)
    force_r & ~match_ev & ~cmp_flag_r |=> ~cmp_flag_r;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("forced compare set the match flag");

  property p_force_read_zero;
    @(posedge hclk) disable iff (!hresetn)
    ap_take & ~hwrite & ap_hi0 & (ap_a == A_CTRL) |=> ~hrdata[7];
  endproperty
  a_force_read_zero: assert property (p_force_read_zero)
    else $error("force strobe read back as one");

  property p_force_pwm;
    @(posedge hclk) disable iff (!hresetn)
    ld_ctrl & ctrl_new[6]
      |=> ~force_r ##1 ((oc_r == $past(oc_r)) | $past(tick));
  endproperty
  a_force_pwm: assert property (p_force_pwm)
    else $error("force strobe acted in a PWM mode");

  property p_override;
    @(posedge hclk) disable iff (!hresetn)
    ld_ctrl & (ctrl_new[5:4] != 2'h0) |=> tmr_out.compare_out_ovr;
  endproperty
  a_override: assert property (p_override)
    else $error("compare output did not take the pin");

  property p_toggle;
    @(posedge hclk) disable iff (!hresetn)
    ~wave[0] & (com == 2'h1) & match_ev |=> oc_r != $past(oc_r);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle mode did not toggle on match");

  property p_count_block;
    @(posedge hclk) disable iff (!hresetn)
    wr_cnt & ~async_sel_r ##1 (cnt_r == ocr_act_r) |-> ~match_ev;
  endproperty
  a_count_block: assert property (p_count_block)
    else $error("match not blocked after counter write");

  property p_busy_set;
    @(posedge hclk) disable iff (!hresetn)
    async_sel_r & wr_cmp |=> busy_r[`T8C_BUSY_CMP];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("compare busy flag not set on async write");

  property p_ctrl_load;
    @(posedge hclk) disable iff (!hresetn)
    async_sel_r & xfer_done[`T8C_BUSY_CTRL] & ~wr_ctrl
      |=> ~busy_r[`T8C_BUSY_CTRL] && (ctrl_r[6:0] == $past(ctrl_tmp_r[6:0]));
  endproperty
  a_ctrl_load: assert property (p_ctrl_load)
    else $error("control not loaded when busy flag cleared");

  property p_match_flag;
    @(posedge hclk) disable iff (!hresetn)
    match_ev |=> cmp_flag_r;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match did not set the match flag");

  property p_ovf_flag;
    @(posedge hclk) disable iff (!hresetn)
    ovf_ev |=> ovf_flag_r;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow did not set its flag");

  property p_ctc_clear;
    @(posedge hclk) disable iff (!hresetn)
    is_ctc & match_ev |=> cnt_r == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("clear-on-match did not clear the counter");

  property p_pc_turn;
    @(posedge hclk) disable iff (!hresetn)
    at_top_pc & ~ld_cnt |=> ~dir_up_r && (cnt_r == 8'hFE);
  endproperty
  a_pc_turn: assert property (p_pc_turn)
    else $error("phase PWM did not turn at top");

  property p_stopped;
    @(posedge hclk) disable iff (!hresetn)
    (ctrl_r.clk_sel == 3'h0) & ~ld_cnt & ~ld_ctrl |=> $stable(cnt_r);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved with clock stopped");

endmodule : t8c_timer
`default_nettype wire

// ### bench/t8c_timer_test.sv
// Self-checking bench for the 8-bit timer behind its AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "t8c_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); \
  end end
module t8c_timer_test;
  localparam logic [31:0] A_FLG = 32'(`T8C_ADDR(`T8C_FLAGS_IDX));
  localparam logic [31:0] A_ASY = 32'(`T8C_ADDR(`T8C_ASYNC_IDX));
  localparam logic [31:0] A_CMP = 32'(`T8C_ADDR(`T8C_CMP_IDX));
  localparam logic [31:0] A_CTL = 32'(`T8C_ADDR(`T8C_CTRL_IDX));
  localparam logic [31:0] A_CNT = 32'(`T8C_ADDR(`T8C_CNT_IDX));
  logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic              xtal_in_pin, cmp_vector_ack, ovf_vector_ack, xtal_run;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  t8c_pkg::t8c_out_t tmr_out;
  int                error_cnt, n_tests, cyc, xdiv, h;

  assign hready = hreadyout;

  t8c_timer DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .xtal_in_pin(xtal_in_pin), .cmp_vector_ack(cmp_vector_ack),
    .ovf_vector_ack(ovf_vector_ack), .tmr_out(tmr_out)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Slow crystal: one toggle every 10 bus clocks, only when enabled.
  always @(posedge hclk) begin
    cyc++;
    if (xtal_run) begin
      xdiv++;
      if (xdiv == 10) begin
        xdiv = 0;
        xtal_in_pin <= ~xtal_in_pin;
      end
    end
    if (cyc == 40000) begin
      `CHK(cyc, 0)
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // One single transfer: address phase, then data phase, each held to hready.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : chk_rd

  function automatic bit inr(input logic [31:0] v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction : inr

  task automatic clks(input int n);
    repeat (n) @(posedge hclk);
  endtask : clks

  task automatic t_reset();
    chk_rd(A_CTL, 32'h0);
    chk_rd(A_CNT, 32'h0);
    chk_rd(A_ASY, 32'h0);
    chk_rd(A_FLG, 32'h0);
    wr(32'h0000_0004, 32'h0000_00FF);
    chk_rd(32'h0000_0004, 32'h0);
    `CHK(tmr_out, 4'h0)
    `CHK(hresp, 1'b0)
  endtask : t_reset

  // Forced matches with the clock stopped: set, clear, toggle twice, then PWM.
  task automatic t_force();
    logic [7:0] fc [5];
    logic       ep [5];
    fc = '{8'hB8, 8'hA8, 8'h98, 8'h98, 8'hF8};
    ep = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    wr(A_CMP, 32'h40);
    wr(A_CNT, 32'h37);
    for (int i = 0; i < 5; i++) begin
      wr(A_CTL, {24'h0, fc[i]});
      clks(3);
      `CHK(tmr_out.compare_out_pin, ep[i])
      `CHK(tmr_out.compare_out_ovr, 1'b1)
    end
    chk_rd(A_CTL, 32'h78);
    chk_rd(A_CNT, 32'h37);
    chk_rd(A_FLG, 32'h0);
    wr(A_CTL, 32'h08);
    clks(2);
    `CHK(tmr_out.compare_out_ovr, 1'b0)
  endtask : t_force

  task automatic wait_flag(input int b);
    h = 0;
    while (tmr_out[b] !== 1'b1 && h < 400) begin
      @(posedge hclk);
      h++;
    end
  endtask : wait_flag

  task automatic t_normal();
    wr(A_CTL, 32'h0);
    wr(A_CMP, 32'h30);
    wr(A_CNT, 32'h0);
    wr(A_FLG, 32'h3);
    wr(A_CTL, 32'h01);
    wait_flag(1);
    `CHK(inr(h, 40, 60), 1'b1)
    ahb(1'b0, A_CNT, 32'h0);
    `CHK(inr(rd, 32'h30, 32'h3C), 1'b1)
    wr(A_FLG, 32'h2);
    chk_rd(A_FLG, 32'h0);
    wait_flag(0);
    `CHK(inr(h, 180, 230), 1'b1)
    ovf_vector_ack <= 1'b1;
    @(posedge hclk);
    ovf_vector_ack <= 1'b0;
    clks(2);
    `CHK(tmr_out.overflow_flag, 1'b0)
    wait_flag(1);
    cmp_vector_ack <= 1'b1;
    @(posedge hclk);
    cmp_vector_ack <= 1'b0;
    clks(2);
    `CHK(tmr_out.compare_match_flag, 1'b0)
  endtask : t_normal

  task automatic t_ctc();
    wr(A_CTL, 32'h0);
    wr(A_CMP, 32'h20);
    wr(A_CNT, 32'h0);
    wr(A_FLG, 32'h3);
    wr(A_CTL, 32'h19);
    repeat (8) begin
      clks(37);
      ahb(1'b0, A_CNT, 32'h0);
      `CHK(inr(rd, 0, 32'h20), 1'b1)
    end
    `CHK(tmr_out.overflow_flag, 1'b0)
  endtask : t_ctc

  task automatic t_presc();
    int dv [6];
    dv = '{8, 32, 64, 128, 256, 1024};
    for (int s = 2; s < 8; s++) begin
      wr(A_CTL, 32'h0);
      wr(A_CNT, 32'h0);
      wr(A_CTL, 32'(s));
      clks(8 * dv[s-2]);
      wr(A_CTL, 32'h0);
      ahb(1'b0, A_CNT, 32'h0);
      `CHK(inr(rd, 7, 10), 1'b1)
    end
    clks(50);
    chk_rd(A_CNT, rd);
    wr(A_CMP, 32'h10);
    wr(A_FLG, 32'h3);
    wr(A_CNT, 32'h10);
    wr(A_CTL, 32'h01);
    clks(2);
    chk_rd(A_FLG, 32'h0);
  endtask : t_presc

  // Duty cycle of the waveform pin over whole periods.
  task automatic t_pwm();
    logic [7:0] cm [6];
    logic [7:0] ct [6];
    int         n [6];
    int         lo [6];
    int         hi [6];
    cm = '{8'h80, 8'h80, 8'hFF, 8'h40, 8'h40, 8'hFF};
    ct = '{8'h69, 8'h79, 8'h69, 8'h61, 8'h71, 8'h61};
    n  = '{512, 512, 512, 1020, 1020, 1020};
    lo = '{248, 248, 512, 248, 756, 1020};
    hi = '{262, 262, 512, 264, 772, 1020};
    for (int i = 0; i < 6; i++) begin
      wr(A_CMP, {24'h0, cm[i]});
      wr(A_CTL, {24'h0, ct[i]});
      clks(1100);
      h = 0;
      repeat (n[i]) begin
        @(posedge hclk);
        if (tmr_out.compare_out_pin === 1'b1) h++;
      end
      `CHK(inr(h, lo[i], hi[i]), 1'b1)
    end
  endtask : t_pwm

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      ahb(1'b0, A_ASY, 32'h0);
      k++;
    end while (rd[2:0] !== 3'b000 && k < 40);
    `CHK(rd, 32'h08)
  endtask : wait_idle

  task automatic t_async();
    wr(A_CTL, 32'h0);
    wr(A_ASY, 32'h08);
    xtal_run = 1'b1;
    wr(A_CNT, 32'h55);
    chk_rd(A_ASY, 32'h0C);
    wait_idle();
    chk_rd(A_CNT, 32'h55);
    wr(A_CMP, 32'h66);
    chk_rd(A_CMP, 32'h66);
    chk_rd(A_ASY, 32'h0A);
    wait_idle();
    wr(A_CNT, 32'h0);
    wait_idle();
    wr(A_CTL, 32'h01);
    chk_rd(A_ASY, 32'h09);
    wait_idle();
    chk_rd(A_CTL, 32'h01);
    clks(200);
    ahb(1'b0, A_CNT, 32'h0);
    `CHK(inr(rd, 8, 13), 1'b1)
  endtask : t_async

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    xtal_in_pin = 1'b0;
    cmp_vector_ack = 1'b0;
    ovf_vector_ack = 1'b0;
    xtal_run = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    xdiv = 0;
    clks(5);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_force();
    t_normal();
    t_ctc();
    t_presc();
    t_pwm();
    t_async();
    end_sim();
  end
endmodule : t8c_timer_test
`default_nettype wire
